/* File: mfs_scheduler.sv */
/*
 * Data FIFO and the transmit scheduler with frame check word
 * generation, plus the receive check. Assumes the PHY and the
 * frame source run on the same clock; straps come from pins.
 */
`timescale 1ns/1ps
`default_nettype none

module mfs_fifo #(
    parameter int W = 9,
    parameter int D = 4
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic [AW:0]   cnt_d;
    logic          push;
    logic          pop;

    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;
    assign out_data = mem_q[rd_q];
    assign cnt_d    = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_q      <= '0;
            rd_q      <= '0;
            cnt_q     <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q     <= cnt_d;
            in_ready  <= cnt_d < (AW+1)'(D);
            out_valid <= cnt_d != '0;
        end
    end
endmodule : mfs_fifo

module mfs_scheduler #(
    parameter int GAP0_CYC   = mfs_pkg::MIN_GAP_B0_CYC,
    parameter int GAP1_CYC   = mfs_pkg::MIN_GAP_B1_CYC,
    parameter int CP_MAX_CYC = mfs_pkg::CP_MAX_CYC
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              low_profile,
    input  wire logic              bandplan_sel,
    input  wire logic              req_valid,
    input  wire mfs_pkg::mfs_req_t req,
    output logic                   req_ready,
    input  wire logic              data_valid,
    input  wire mfs_pkg::mfs_byte_t data,
    output logic                   data_ready,
    input  wire logic              medium_busy,
    input  wire logic              backoff_expire,
    output logic                   grant_valid,
    output mfs_pkg::mfs_grant_t    grant,
    output logic                   phy_bit,
    output logic                   phy_valid,
    output logic                   phy_last,
    input  wire logic              phy_ready,
    output logic [1:0]             phy_prio,
    output logic                   slot_tick,
    input  wire logic              rx_bit,
    input  wire logic              rx_valid,
    input  wire logic              rx_last,
    output logic                   rx_done,
    output logic                   rx_error
);
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b);
        crc_step = {c[30:0], 1'b0} ^ ((b ^ c[31]) ? mfs_pkg::FCW_POLY : 32'h0);
    endfunction : crc_step

    function automatic logic [5:0] retry_budget(input logic [6:0] n);
        logic [6:0] r;
        r = 7'h00;
        if (n <= 7'h05) begin
            r = n * 7'h03;
        end else if (n <= 7'h0A) begin
            r = 7'h0F + n * 7'h02;
        end else if (n <= 7'h14) begin
            r = 7'h0F + n;
        end else if (n <= 7'h1F) begin
            r = 7'h23 + ((n - 7'h14) >> 1);
        end else if (n <= 7'h2E) begin
            r = 7'h29 + (n - 7'h20) / 7'h03;
        end else begin
            r = 7'h2E + ((n - 7'h2F) >> 2);
        end
        retry_budget = r[5:0];
    endfunction : retry_budget

    function automatic logic [1:0] assign_prio(input mfs_pkg::mfs_req_t r, input logic low);
        logic [1:0] p;
        p = 2'h0;
        unique case (r.kind)
            mfs_pkg::KIND_APP:  p = (r.app_prio == 2'h3) ? mfs_pkg::PRIO_MGMT : r.app_prio;
            mfs_pkg::KIND_MGMT: p = mfs_pkg::PRIO_MGMT;
            default:            p = mfs_pkg::PRIO_EMERG;
        endcase
        if (low) begin
            p = {p[1], 1'b0};
        end
        if (r.later && r.elevate && p < mfs_pkg::PRIO_MGMT) begin
            p = mfs_pkg::PRIO_MGMT;
        end
        assign_prio = p;
    endfunction : assign_prio

    // straps: three stages, change taken when stages two and three agree
    logic [1:0] cfg_s1_q;
    logic [1:0] cfg_s2_q;
    logic [1:0] cfg_s3_q;
    logic [1:0] cfg_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_s1_q <= 2'h0;
            cfg_s2_q <= 2'h0;
            cfg_s3_q <= 2'h0;
            cfg_q    <= 2'h0;
        end else begin
            cfg_s1_q <= {low_profile, bandplan_sel};
            cfg_s2_q <= cfg_s1_q;
            cfg_s3_q <= cfg_s2_q;
            if (cfg_s2_q == cfg_s3_q) begin
                cfg_q <= cfg_s3_q;
            end
        end
    end

    mfs_pkg::mfs_state_t st_q;
    mfs_pkg::mfs_desc_t  s_desc_q;
    mfs_pkg::mfs_desc_t  q_mem_q [mfs_pkg::NUM_PRIO][mfs_pkg::QUEUE_D];
    mfs_pkg::mfs_desc_t  pick;
    mfs_pkg::mfs_byte_t  byte_q;
    mfs_pkg::mfs_byte_t  fifo_out;
    logic                s_v_q;
    logic [1:0]          q_cnt_q [mfs_pkg::NUM_PRIO];
    logic                q_wr_q  [mfs_pkg::NUM_PRIO];
    logic                q_rd_q  [mfs_pkg::NUM_PRIO];
    logic                move;
    logic                any;
    logic [1:0]          sel;
    logic                go;
    logic                accept;
    logic                adv;
    logic                fifo_valid;
    logic                fifo_pop;
    logic                byte_v_q;
    logic [2:0]          bidx_q;
    logic [31:0]         crc_q;
    logic [4:0]          mcnt_q;
    logic [4:0]          fcnt_q;
    logic [18:0]         gap_cnt_q;
    logic [24:0]         cp_cnt_q;
    logic                busy_seen_q;
    logic [15:0]         slot_cnt_q;
    logic                inv;

    assign accept   = req_valid && req_ready;
    assign move     = s_v_q && (q_cnt_q[s_desc_q.prio] != 2'h2);
    assign adv      = !phy_valid || phy_ready;
    assign fifo_pop = (st_q == mfs_pkg::ST_SEND) && !byte_v_q && fifo_valid;
    assign inv      = mcnt_q < mfs_pkg::FCW_INV_BITS;

    always_comb begin
        any = 1'b0;
        sel = 2'h0;
        for (int i = 0; i < mfs_pkg::NUM_PRIO; i++) begin
            if (q_cnt_q[i] != 2'h0) begin
                any = 1'b1;
                sel = 2'(i);
            end
        end
        pick = q_mem_q[sel][q_rd_q[sel]];
    end

    assign go = (st_q == mfs_pkg::ST_CONTEND) && any
             && (backoff_expire || (cp_cnt_q >= 25'(CP_MAX_CYC) && !busy_seen_q));

    // staging register keeps req_ready a flop
    always_ff @(posedge clock) begin
        if (rst) begin
            s_v_q     <= 1'b0;
            s_desc_q  <= '0;
            req_ready <= 1'b0;
        end else begin
            if (accept) begin
                s_v_q <= 1'b1;
                s_desc_q <= '{prio: assign_prio(req, cfg_q[1]), nseg: req.nseg};
            end else if (move) begin
                s_v_q <= 1'b0;
            end
            req_ready <= !((s_v_q && !move) || accept);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < mfs_pkg::NUM_PRIO; i++) begin
                q_cnt_q[i] <= 2'h0;
                q_wr_q[i]  <= 1'b0;
                q_rd_q[i]  <= 1'b0;
            end
        end else begin
            for (int i = 0; i < mfs_pkg::NUM_PRIO; i++) begin
                if (move && s_desc_q.prio == 2'(i)) begin
                    q_mem_q[i][q_wr_q[i]] <= s_desc_q;
                    q_wr_q[i] <= !q_wr_q[i];
                end
                if (go && sel == 2'(i)) begin
                    q_rd_q[i] <= !q_rd_q[i];
                end
                q_cnt_q[i] <= q_cnt_q[i] + 2'(move && s_desc_q.prio == 2'(i))
                                         - 2'(go && sel == 2'(i));
            end
        end
    end

    mfs_fifo #(
        .W($bits(mfs_pkg::mfs_byte_t)),
        .D(mfs_pkg::DATA_FIFO_D)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_data   (data),
        .in_valid  (data_valid),
        .in_ready  (data_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    always_ff @(posedge clock) begin
        if (rst) begin
            st_q <= mfs_pkg::ST_GAP;
        end else begin
            unique case (st_q)
                mfs_pkg::ST_GAP: begin
                    if (gap_cnt_q == 19'(cfg_q[0] ? GAP1_CYC - 1 : GAP0_CYC - 1)) begin
                        st_q <= mfs_pkg::ST_CONTEND;
                    end
                end
                mfs_pkg::ST_CONTEND: begin
                    if (go) begin
                        st_q <= mfs_pkg::ST_SEND;
                    end
                end
                mfs_pkg::ST_SEND: begin
                    if (adv && byte_v_q && bidx_q == 3'h7 && byte_q.last) begin
                        st_q <= mfs_pkg::ST_FCW;
                    end
                end
                mfs_pkg::ST_FCW: begin
                    if (adv && fcnt_q == 5'h1F) begin
                        st_q <= mfs_pkg::ST_GAP;
                    end
                end
            endcase
        end
    end

    // contention timers restart at each period start
    always_ff @(posedge clock) begin
        if (rst) begin
            gap_cnt_q   <= '0;
            cp_cnt_q    <= '0;
            busy_seen_q <= 1'b0;
            slot_cnt_q  <= '0;
            slot_tick   <= 1'b0;
        end else begin
            gap_cnt_q <= (st_q == mfs_pkg::ST_GAP) ? gap_cnt_q + 19'h1 : '0;
            if (st_q != mfs_pkg::ST_CONTEND) begin
                cp_cnt_q    <= '0;
                busy_seen_q <= 1'b0;
                slot_cnt_q  <= '0;
                slot_tick   <= 1'b0;
            end else begin
                if (cp_cnt_q != 25'h1FFFFFF) begin
                    cp_cnt_q <= cp_cnt_q + 25'h1;
                end
                busy_seen_q <= busy_seen_q || medium_busy;
                slot_tick  <= slot_cnt_q == 16'(mfs_pkg::SLOT_CYC - 1);
                slot_cnt_q <= (slot_cnt_q == 16'(mfs_pkg::SLOT_CYC - 1)) ? '0
                            : slot_cnt_q + 16'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            grant_valid <= 1'b0;
            grant       <= '0;
            phy_prio    <= 2'h0;
        end else begin
            grant_valid <= go;
            if (go) begin
                grant    <= '{prio: pick.prio, nseg: pick.nseg,
                              budget: retry_budget(pick.nseg)};
                phy_prio <= pick.prio;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            byte_v_q  <= 1'b0;
            byte_q    <= '0;
            bidx_q    <= 3'h0;
            crc_q     <= '0;
            mcnt_q    <= 5'h0;
            fcnt_q    <= 5'h0;
            phy_bit   <= 1'b0;
            phy_valid <= 1'b0;
            phy_last  <= 1'b0;
        end else begin
            if (fifo_pop) begin
                byte_v_q <= 1'b1;
                byte_q   <= fifo_out;
                bidx_q   <= 3'h0;
            end
            if (st_q == mfs_pkg::ST_CONTEND) begin
                crc_q  <= '0;
                mcnt_q <= 5'h0;
                fcnt_q <= 5'h0;
            end
            if (adv) begin
                phy_valid <= 1'b0;
                phy_last  <= 1'b0;
                if (st_q == mfs_pkg::ST_SEND && byte_v_q) begin
                    phy_bit   <= byte_q.data[bidx_q];
                    phy_valid <= 1'b1;
                    crc_q     <= crc_step(crc_q, byte_q.data[bidx_q] ^ inv);
                    mcnt_q    <= inv ? mcnt_q + 5'h1 : mcnt_q;
                    bidx_q    <= bidx_q + 3'h1;
                    if (bidx_q == 3'h7) begin
                        byte_v_q <= 1'b0;
                    end
                end else if (st_q == mfs_pkg::ST_FCW) begin
                    phy_bit   <= ~crc_q[31];
                    phy_valid <= 1'b1;
                    phy_last  <= fcnt_q == 5'h1F;
                    crc_q     <= {crc_q[30:0], 1'b0};
                    fcnt_q    <= fcnt_q + 5'h1;
                end
            end
        end
    end

    // receive check: last 32 bits held back as the check word
    logic [31:0] rx_dl_q;
    logic [31:0] rx_crc_q;
    logic [31:0] rx_crc_d;
    logic [5:0]  rx_cnt_q;
    logic [4:0]  rx_m_q;
    logic        rx_full;
    logic        rx_inv;

    assign rx_full  = rx_cnt_q == 6'h20;
    assign rx_inv   = rx_m_q < mfs_pkg::FCW_INV_BITS;
    assign rx_crc_d = crc_step(rx_crc_q, rx_dl_q[31] ^ rx_inv);

    always_ff @(posedge clock) begin
        if (rst) begin
            rx_dl_q  <= '0;
            rx_crc_q <= '0;
            rx_cnt_q <= 6'h0;
            rx_m_q   <= 5'h0;
            rx_done  <= 1'b0;
            rx_error <= 1'b0;
        end else begin
            rx_done <= rx_valid && rx_last;
            if (rx_valid && rx_last) begin
                rx_error <= !rx_full || ({rx_dl_q[30:0], rx_bit} != ~rx_crc_d);
                rx_dl_q  <= '0;
                rx_crc_q <= '0;
                rx_cnt_q <= 6'h0;
                rx_m_q   <= 5'h0;
            end else if (rx_valid) begin
                rx_dl_q <= {rx_dl_q[30:0], rx_bit};
                if (rx_full) begin
                    rx_crc_q <= rx_crc_d;
                    rx_m_q   <= rx_inv ? rx_m_q + 5'h1 : rx_m_q;
                end else begin
                    rx_cnt_q <= rx_cnt_q + 6'h1;
                end
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence start_seq;
        go ##1 grant_valid;
    endsequence

    gap_length_a: assert property (
        $rose(st_q == mfs_pkg::ST_CONTEND) |->
        $past(gap_cnt_q) == 19'(cfg_q[0] ? GAP1_CYC - 1 : GAP0_CYC - 1))
        else $error("gap shorter or longer than minimum");

    start_window_a: assert property (
        (backoff_expire && any && st_q == mfs_pkg::ST_CONTEND) |-> start_seq)
        else $error("frame not started after back-off expiry");

    fcw_tail_a: assert property (
        (phy_last && phy_ready) |-> st_q == mfs_pkg::ST_GAP && fcnt_q == 5'h0)
        else $error("check word length wrong");

    low_prio_a: assert property (
        (grant_valid && cfg_q[1]) |-> !grant.prio[0])
        else $error("low profile granted odd priority");

    budget_small_a: assert property (
        (grant_valid && grant.nseg <= 7'h05) |-> 7'(grant.budget) == grant.nseg * 7'h03)
        else $error("retry budget wrong for short frame");

    mgmt_prio_a: assert property (
        (accept && req.kind == mfs_pkg::KIND_MGMT) |=> s_desc_q.prio == mfs_pkg::PRIO_MGMT)
        else $error("management frame not at priority two");

    app_cap_a: assert property (
        (accept && req.kind == mfs_pkg::KIND_APP) |=> s_desc_q.prio != mfs_pkg::PRIO_EMERG)
        else $error("application frame reached emergency priority");

    keep_high_a: assert property (
        (accept && req.kind == mfs_pkg::KIND_APP && req.app_prio == 2'h2)
        |=> s_desc_q.prio == 2'h2)
        else $error("high application priority changed");

    slot_period_a: assert property (
        slot_tick |-> $past(slot_cnt_q) == 16'(mfs_pkg::SLOT_CYC - 1))
        else $error("slot tick off period");

    highest_first_a: assert property (
        (go && q_cnt_q[3] != 2'h0) |=> grant.prio == 2'h3)
        else $error("emergency queue bypassed");

endmodule : mfs_scheduler

`default_nettype wire

/* File: mfs_pkg.sv */
/*
 * Shared constants and types for the transmit frame check and
 * priority scheduler. Assumes one 100 MHz clock for every user.
 */
// How it works
// - check word covers whole frame, transmission order
// - generator polynomial is fixed degree 32
// - first sent bit is highest coefficient
// - first sixteen message bits are inverted
// - check word is inverted division remainder
// - check word sent highest power first
// - scheduler picks frame and start time
// - minimum gap 2.1 or 2.7 ms
// - slot lasts two preamble symbols
// - retry budget from segment count table
// - standard node has four priorities 0..3
// - low complexity node uses 0 and 2
// - application priorities 0..2, 3 emergency only
// - management frames always at priority 2
// - priority never beyond supported queue count
// - three data queues plus emergency queue
// - other profiles keep priorities 0 and 2
// - frame starts with its LLC priority
// - later segments may rise to 2
// - priority 2 and above never elevated
// - start soon after back-off expiry boundary
// - idle contention past limit sends at once
package mfs_pkg;

    localparam real CLK_MHZ = 100.0;

    localparam real MIN_GAP_B0_MS = 2.1;
    localparam real MIN_GAP_B1_MS = 2.7;
    localparam real CP_MAX_MS     = 250.0;
    localparam real TX_ON_US      = 10.0;

    // small epsilon keeps float noise from adding a cycle to a ceiling or dropping one from a floor
    localparam int MIN_GAP_B0_CYC = int'($ceil(MIN_GAP_B0_MS * CLK_MHZ * 1000.0 - 0.001));
    localparam int MIN_GAP_B1_CYC = int'($ceil(MIN_GAP_B1_MS * CLK_MHZ * 1000.0 - 0.001));
    localparam int CP_MAX_CYC     = int'($ceil(CP_MAX_MS * CLK_MHZ * 1000.0 - 0.001));
    localparam int TX_ON_CYC      = int'($floor(TX_ON_US * CLK_MHZ + 0.001));

    localparam int PREAMBLE_SYM_CYC = 64;
    localparam int SLOT_SYMBOLS     = 2;
    localparam int SLOT_CYC         = SLOT_SYMBOLS * PREAMBLE_SYM_CYC;

    localparam logic [31:0] FCW_POLY     = 32'h1EDC6F41;
    localparam int          FCW_W        = 32;
    localparam logic [4:0]  FCW_INV_BITS = 5'h10;

    localparam int         NUM_PRIO   = 4;
    localparam int         QUEUE_D    = 2;
    localparam int         DATA_FIFO_D = 4;
    localparam logic [1:0] PRIO_MGMT  = 2'h2;
    localparam logic [1:0] PRIO_EMERG = 2'h3;

    typedef enum logic [1:0] {
        KIND_APP    = 2'h0,
        KIND_MGMT   = 2'h1,
        KIND_EMERG  = 2'h2,
        KIND_BEACON = 2'h3
    } mfs_kind_t;

    typedef enum logic [1:0] {
        ST_GAP     = 2'h0,
        ST_CONTEND = 2'h1,
        ST_SEND    = 2'h2,
        ST_FCW     = 2'h3
    } mfs_state_t;

    typedef struct packed {
        mfs_kind_t  kind;
        logic [1:0] app_prio;
        logic [6:0] nseg;
        logic       later;
        logic       elevate;
    } mfs_req_t;

    typedef struct packed {
        logic [1:0] prio;
        logic [6:0] nseg;
    } mfs_desc_t;

    typedef struct packed {
        logic [1:0] prio;
        logic [6:0] nseg;
        logic [5:0] budget;
    } mfs_grant_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } mfs_byte_t;

endpackage : mfs_pkg

/* File: mfs_phy_model.sv */
/*
 * PHY-side bit sink for the scheduler bench.
 * Assumes the scheduler clock; keeps accepted bits in order.
 */
`timescale 1ns/1ps
`default_nettype none

module mfs_phy_model (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic slow,
    input  wire logic phy_bit,
    input  wire logic phy_valid,
    input  wire logic phy_last,
    output logic      phy_ready
);
    logic tog_q;
    logic pend_q;
    logic pbit_q;
    logic bits_q[$];
    int   last_idx = -1;
    int   hold_err = 0;

    // slow mode stalls every other cycle so holding is exercised
    always_ff @(posedge clock) begin
        if (rst) tog_q <= 1'h0;
        else tog_q <= ~tog_q;
    end

    assign phy_ready = !rst && (!slow || tog_q);

    always @(posedge clock) begin
        if (!rst && pend_q && (phy_valid !== 1'h1 || phy_bit !== pbit_q)) hold_err++;
        if (!rst && phy_valid && phy_ready) begin
            bits_q.push_back(phy_bit);
            if (phy_last) last_idx = bits_q.size() - 1;
        end
        pend_q <= !rst && phy_valid && !phy_ready;
        pbit_q <= phy_bit;
    end
endmodule : mfs_phy_model

`default_nettype wire

/* File: mfs_scheduler_bench.sv */
/*
 * Bench for the transmit scheduler: order, budgets, check word,
 * receive check. Assumes mfs_pkg and the PHY model compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module mfs_scheduler_bench;
    logic                clock, rst, req_valid, data_valid, backoff_expire;
    logic                rx_bit, rx_valid, rx_last, slow;
    logic                low_profile, bandplan_sel, medium_busy;
    logic                req_ready, data_ready, grant_valid, phy_bit, phy_valid;
    logic                phy_last, phy_ready, slot_tick, rx_done, rx_error;
    logic [1:0]          phy_prio;
    mfs_pkg::mfs_req_t   req;
    mfs_pkg::mfs_byte_t  data;
    mfs_pkg::mfs_grant_t grant;
    logic                exp_q[$];
    int                  bad_count = 0;
    int                  checks = 0;

    mfs_scheduler #(.GAP0_CYC(20), .GAP1_CYC(30), .CP_MAX_CYC(200)) u_mfs_scheduler (
        .clock, .rst, .low_profile, .bandplan_sel, .req_valid, .req,
        .req_ready, .data_valid, .data, .data_ready, .medium_busy,
        .backoff_expire, .grant_valid, .grant, .phy_bit, .phy_valid, .phy_last,
        .phy_ready, .phy_prio, .slot_tick, .rx_bit, .rx_valid, .rx_last, .rx_done,
        .rx_error);

    mfs_phy_model u_mfs_phy_model (.clock, .rst, .slow, .phy_bit, .phy_valid,
        .phy_last, .phy_ready);

    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic complete_run;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    task automatic timed_out(input string what);
        bad_count++;
        $display("MISMATCH %s expected done seen timeout", what);
        complete_run();
    endtask : timed_out

    function automatic int budget(input int n);
        if (n <= 5) return 3 * n;
        if (n <= 10) return 15 + 2 * n;
        if (n <= 20) return 15 + n;
        if (n <= 31) return 35 + (n - 20) / 2;
        if (n <= 46) return 41 + (n - 32) / 3;
        return 46 + (n - 47) / 4;
    endfunction : budget

    // first sixteen bits inverted, remainder inverted on output
    function automatic logic [31:0] fcw();
        logic [31:0] r;
        logic        fb;
        r = 32'h0;
        for (int i = 0; i < 32; i++) begin
            fb = r[31] ^ exp_q[i] ^ (i < 16);
            r = {r[30:0], 1'h0};
            if (fb) r = r ^ 32'h1EDC6F41;
        end
        return ~r;
    endfunction : fcw

    task automatic enqueue(input mfs_pkg::mfs_kind_t k, input logic [1:0] p,
                           input logic [6:0] n, input logic up);
        int i;
        req <= '{kind: k, app_prio: p, nseg: n, later: up, elevate: up};
        req_valid <= 1'h1;
        i = 0;
        do begin @(posedge clock); i++; end while (req_ready !== 1'h1 && i < 50);
        if (req_ready !== 1'h1) timed_out("req_ready");
        req_valid <= 1'h0;
        @(posedge clock);
    endtask : enqueue

    task automatic deliver(input logic [1:0] prio, input int n, input logic bo,
                           input logic [7:0] base);
        int          i;
        int          j;
        logic [7:0]  b;
        logic [31:0] c;
        exp_q.delete();
        u_mfs_phy_model.bits_q.delete();
        u_mfs_phy_model.last_idx = -1;
        for (i = 0; i < 32; i++) begin
            b = base + 8'(i / 8);
            exp_q.push_back(b[i % 8]);
        end
        c = fcw();
        for (i = 31; i >= 0; i--) exp_q.push_back(c[i]);
        for (i = 0; i < 4; i++) begin
            data <= {base + 8'(i), i == 3};
            data_valid <= 1'h1;
            j = 0;
            do begin @(posedge clock); j++; end while (data_ready !== 1'h1 && j < 50);
            if (data_ready !== 1'h1) timed_out("data_ready");
        end
        data_valid <= 1'h0;
        @(posedge clock);
        chk("data_ready full", 32'h0, 32'(data_ready));
        i = 0;
        do begin
            backoff_expire <= bo && (i % 8 == 7);
            @(posedge clock);
            i++;
        end while (grant_valid !== 1'h1 && i < 2000);
        backoff_expire <= 1'h0;
        if (grant_valid !== 1'h1) timed_out("grant");
        chk("grant prio", 32'(prio), 32'(grant.prio));
        chk("phy_prio", 32'(prio), 32'(phy_prio));
        chk("grant nseg", 32'(n), 32'(grant.nseg));
        chk("budget", 32'(budget(n)), 32'(grant.budget));
        i = 0;
        do begin @(posedge clock); i++; end
        while (u_mfs_phy_model.bits_q.size() < 64 && i < 5000);
        if (u_mfs_phy_model.bits_q.size() != 64) timed_out("phy bits");
        for (i = 0; i < 64; i++) chk("bit", 32'(exp_q[i]), 32'(u_mfs_phy_model.bits_q[i]));
        chk("last", 32'h3F, 32'(u_mfs_phy_model.last_idx));
    endtask : deliver

    task automatic rx_check(input logic flip);
        int i;
        for (i = 0; i < 64; i++) begin
            rx_bit <= exp_q[i] ^ (flip && i == 5);
            rx_valid <= 1'h1;
            rx_last <= (i == 63);
            @(posedge clock);
        end
        rx_valid <= 1'h0;
        rx_last <= 1'h0;
        i = 0;
        do begin @(posedge clock); i++; end while (rx_done !== 1'h1 && i < 10);
        if (rx_done !== 1'h1) timed_out("rx_done");
        chk("rx_error", 32'(flip), 32'(rx_error));
    endtask : rx_check

    task automatic t_order;
        enqueue(mfs_pkg::KIND_APP, 2'h0, 7'h2F, 1'h0);
        enqueue(mfs_pkg::KIND_MGMT, 2'h0, 7'h15, 1'h0);
        deliver(2'h2, 21, 1'h1, 8'h11);
        deliver(2'h0, 47, 1'h0, 8'hA0);
    endtask : t_order

    task automatic t_emerg;
        int i;
        int n;
        n = 0;
        // busy medium must block the idle-period start
        medium_busy <= 1'h1;
        enqueue(mfs_pkg::KIND_EMERG, 2'h0, 7'h40, 1'h0);
        for (i = 0; i < 300; i++) begin
            @(posedge clock);
            n += int'(grant_valid === 1'h1);
        end
        chk("busy grants", 32'h0, 32'(n));
        medium_busy <= 1'h0;
        deliver(2'h3, 64, 1'h1, 8'h5A);
        // straps need the synchroniser to settle before the next request
        low_profile <= 1'h1;
        bandplan_sel <= 1'h1;
        repeat (5) @(posedge clock);
        enqueue(mfs_pkg::KIND_EMERG, 2'h0, 7'h40, 1'h0);
        deliver(2'h2, 64, 1'h1, 8'h3C);
    endtask : t_emerg

    task automatic t_elev;
        slow <= 1'h1;
        enqueue(mfs_pkg::KIND_APP, 2'h1, 7'h05, 1'h1);
        deliver(2'h2, 5, 1'h1, 8'hC3);
        slow <= 1'h0;
        chk("hold", 32'h0, 32'(u_mfs_phy_model.hold_err));
        rx_check(1'h0);
        rx_check(1'h1);
    endtask : t_elev

    initial begin
        rst = 1'h1;
        slow = 1'h0;
        low_profile = 1'h0;
        bandplan_sel = 1'h0;
        medium_busy = 1'h0;
        req_valid = 1'h0;
        req = '0;
        data_valid = 1'h0;
        data = '0;
        backoff_expire = 1'h0;
        rx_bit = 1'h0;
        rx_valid = 1'h0;
        rx_last = 1'h0;
        repeat (8) @(posedge clock);
        chk("req_ready reset", 32'h0, 32'(req_ready));
        chk("phy_valid reset", 32'h0, 32'(phy_valid));
        rst <= 1'h0;
        t_order();
        t_emerg();
        t_elev();
        complete_run();
    end
endmodule : mfs_scheduler_bench

`default_nettype wire
